// ===== rtl/aacs_limit_ram.v
`timescale 1ns/10ps
`default_nettype none
`include "aacs_map.vh"

module aacs_limit_ram (
	// Clock and reset
	input  wire                    aclk,
	input  wire                    aresetn,
	// Write port
	input  wire                    we,
	input  wire [`AACS_LIM_AW-1:0] waddr,
	input  wire [`AACS_LIM_DW-1:0] wdata,
	// Registered read port
	input  wire [`AACS_LIM_AW-1:0] raddr,
	output reg  [`AACS_LIM_DW-1:0] rdata
);

	reg [`AACS_LIM_DW-1:0] mem [0:`AACS_LIM_DEPTH-1];

	// Reset opens every window fully so no alert fires before software sets limits.
	genvar gi;
	generate
		for (gi = 0; gi < `AACS_LIM_DEPTH; gi = gi + 1) begin : g_word
			always @(posedge aclk) begin
				if (!aresetn) begin
					mem[gi] <= (gi % 3 == 1) ? `AACS_LIM_HIGH_RST : `AACS_LIM_LOW_RST;
				end else if (we && waddr == gi) begin
					mem[gi] <= wdata;
				end
			end
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= {`AACS_LIM_DW{1'b0}};
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule // aacs_limit_ram

`default_nettype wire

// ===== rtl/aacs_map.vh
`ifndef AACS_MAP_VH
`define AACS_MAP_VH

// Register indices; the byte address is four times the index.
`define AACS_IDX_RESULT      4'h0
`define AACS_IDX_CHANNEL     4'h1
`define AACS_IDX_CONFIG      4'h2
`define AACS_IDX_ALERT       4'h3
`define AACS_IDX_LIMIT_BASE  4'h4
`define AACS_ADDR_W          8
`define AACS_ADDR_TOP        7:6
`define AACS_ADDR_IDX        5:2

// Configuration register fields.
`define AACS_CFG_DRIVE       15
`define AACS_CFG_CMD         10
`define AACS_CFG_SWRST       9
`define AACS_CFG_AUTO        8
`define AACS_CFG_CYCLE       7:6
`define AACS_CFG_BUSY        5
`define AACS_CFG_ALERT_EN    4
`define AACS_CFG_POL         3
`define AACS_CFG_PD_UP       1
`define AACS_CFG_PD_REF      0
`define AACS_CFG_RESET       16'h00C3
`define AACS_CFG_RW_MASK     16'h85FB

// Result word layout.
`define AACS_RES_CHAN        14:13
`define AACS_RES_ALERT       12
`define AACS_RES_DATA        11:0

// Limit memory: per channel low, high and hysteresis words.
`define AACS_LIM_LOW         2'h0
`define AACS_LIM_HIGH        2'h1
`define AACS_LIM_HYST        2'h2
`define AACS_LIM_DEPTH       12
`define AACS_LIM_AW          4
`define AACS_LIM_DW          12
`define AACS_LIM_LOW_RST     12'h000
`define AACS_LIM_HIGH_RST    12'hFFF

// AXI responses.
`define AACS_RESP_OKAY       2'h0
`define AACS_RESP_SLVERR     2'h2

// Timing.
`define AACS_CLK_PERIOD_NS   100
`define AACS_BASE_TIME_NS    100000
`define AACS_BASE_CYCLES     (`AACS_BASE_TIME_NS / `AACS_CLK_PERIOD_NS)
`define AACS_TMR_W           14

`endif

// ===== rtl/aacs_sequencer.v
`timescale 1ns/10ps
`default_nettype none
`include "aacs_map.vh"

module aacs_sequencer #(
	parameter integer BASE_CYCLES = `AACS_BASE_CYCLES
) (
	// Clock and reset
	input  wire                    aclk,
	input  wire                    aresetn,
	// AXI4-Lite write address
	input  wire [`AACS_ADDR_W-1:0] s_axi_awaddr,
	input  wire                    s_axi_awvalid,
	output wire                    s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	input  wire                    s_axi_wvalid,
	output wire                    s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]              s_axi_bresp,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	// AXI4-Lite read address
	input  wire [`AACS_ADDR_W-1:0] s_axi_araddr,
	input  wire                    s_axi_arvalid,
	output wire                    s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready,
	// Serial bus events
	input  wire                    scl_pin_i,
	input  wire                    bus_stop_i,
	// Conversion core
	input  wire                    ext_conv_req_i,
	output reg                     conv_start_o,
	output reg  [1:0]              conv_chan_o,
	input  wire                    conv_done_i,
	input  wire [11:0]             conv_data_i,
	// Power control
	output wire                    analog_on_o,
	output wire                    ref_on_o,
	// Shared status pin
	output reg                     shared_status_pin_o,
	output reg                     shared_status_pin_oe
);

	localparam [2:0] CMP_IDLE = 3'h0;
	localparam [2:0] CMP_LOW  = 3'h1;
	localparam [2:0] CMP_HIGH = 3'h2;
	localparam [2:0] CMP_HYST = 3'h3;
	localparam [2:0] CMP_EVAL = 3'h4;

	reg  [15:0]               config_q;
	reg  [3:0]                chan_reg_q;
	reg  [3:0]                active_mask_q;
	reg                       chan_pend_q;
	reg  [1:0]                cur_ch_q;
	reg  [7:0]                alert_q;
	reg  [7:0]                alert_d;
	reg  [1:0]                res_chan_q;
	reg  [11:0]               res_data_q;
	reg                       conv_q;
	reg                       stopped_q;
	reg  [`AACS_TMR_W-1:0]    tmr_q;
	reg  [1:0]                hold_edges_q;
	reg                       scl_prev_q;
	reg  [2:0]                cmp_state_q;
	reg  [1:0]                cmp_ch_q;
	reg  [11:0]               cmp_data_q;
	reg  [11:0]               cmp_low_q;
	reg  [11:0]               cmp_high_q;
	reg                       aw_q;
	reg                       w_q;
	reg  [`AACS_ADDR_W-1:0]   awaddr_q;
	reg  [31:0]               wdata_q;
	reg  [3:0]                wstrb_q;
	reg                       ar_q;
	reg  [`AACS_ADDR_W-1:0]   araddr_q;
	reg                       rd_mem_q;
	reg  [`AACS_LIM_AW-1:0]   ram_raddr;
	wire [`AACS_LIM_DW-1:0]   ram_rdata;
	wire                      scl_sync;

	wire [3:0]  w_idx      = awaddr_q[`AACS_ADDR_IDX];
	wire        w_ok       = (awaddr_q[`AACS_ADDR_TOP] == 2'h0);
	wire [3:0]  r_idx      = araddr_q[`AACS_ADDR_IDX];
	wire        r_ok       = (araddr_q[`AACS_ADDR_TOP] == 2'h0);
	wire        do_write   = aw_q && w_q && !s_axi_bvalid;
	wire        r_is_lim   = (r_idx >= `AACS_IDX_LIMIT_BASE);
	wire        rd_go      = ar_q && !s_axi_rvalid && !rd_mem_q &&
	                         !(r_ok && r_is_lim && cmp_state_q != CMP_IDLE);
	wire        wr_lim     = do_write && w_ok && (w_idx >= `AACS_IDX_LIMIT_BASE);
	wire        wr_chan    = do_write && w_ok && (w_idx == `AACS_IDX_CHANNEL);
	wire        wr_cfg     = do_write && w_ok && (w_idx == `AACS_IDX_CONFIG);
	wire [15:0] wr_merged  = merge16(config_q, wdata_q[15:0], wstrb_q[1:0]);
	wire        swrst      = wr_cfg && wr_merged[`AACS_CFG_SWRST];
	wire        rd_alert   = rd_go && r_ok && (r_idx == `AACS_IDX_ALERT);
	wire        auto_mode  = !config_q[`AACS_CFG_CMD] && config_q[`AACS_CFG_AUTO];
	wire        cmd_mode   = config_q[`AACS_CFG_CMD] && !config_q[`AACS_CFG_AUTO];
	wire        scl_edge   = scl_sync ^ scl_prev_q;
	wire [31:0] period_w   = BASE_CYCLES << config_q[`AACS_CFG_CYCLE];
	wire [`AACS_TMR_W-1:0] period = period_w[`AACS_TMR_W-1:0];
	wire        tmr_fire   = auto_mode && hold_edges_q == 2'h0 && tmr_q == period - 1'b1;
	wire        conv_req   = auto_mode ? tmr_fire : ext_conv_req_i;
	wire        any_alert  = |alert_q;
	wire [12:0] data_x     = {1'b0, cmp_data_q};
	wire        over_high  = cmp_data_q > cmp_high_q;
	wire        under_low  = cmp_data_q < cmp_low_q;
	wire        back_high  = (data_x + {1'b0, ram_rdata}) < {1'b0, cmp_high_q};
	wire        back_low   = data_x > ({1'b0, cmp_low_q} + {1'b0, ram_rdata});

	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_q && !s_axi_bvalid;
	assign s_axi_arready = !ar_q;
	// In command mode a bus stop lets the analog side sleep until the next request.
	assign analog_on_o   = config_q[`AACS_CFG_PD_UP] && (auto_mode || !stopped_q);
	assign ref_on_o      = config_q[`AACS_CFG_PD_UP] && config_q[`AACS_CFG_PD_REF];

	function [15:0] merge16;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  strb;
		begin
			merge16[15:8] = strb[1] ? nw[15:8] : old[15:8];
			merge16[7:0]  = strb[0] ? nw[7:0] : old[7:0];
		end
	endfunction

	function [1:0] lowest;
		input [3:0] mask;
		integer i;
		begin
			lowest = 2'h0;
			for (i = 3; i >= 0; i = i - 1) begin
				if (mask[i]) begin
					lowest = i[1:0];
				end
			end
		end
	endfunction

	function [1:0] next_ch;
		input [3:0] mask;
		input [1:0] cur;
		integer i;
		reg found;
		begin
			found = 1'b0;
			next_ch = lowest(mask);
			for (i = 0; i < 4; i = i + 1) begin
				if (!found && mask[i] && i > cur) begin
					next_ch = i[1:0];
					found = 1'b1;
				end
			end
		end
	endfunction

	aacs_sync u_scl_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.async_i (scl_pin_i),
		.sync_o  (scl_sync)
	);

	aacs_limit_ram u_limits (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (wr_lim),
		.waddr   (w_idx - `AACS_IDX_LIMIT_BASE),
		.wdata   (wdata_q[`AACS_LIM_DW-1:0]),
		.raddr   (ram_raddr),
		.rdata   (ram_rdata)
	);

	// The comparator owns the read port while busy; bus reads of limit words wait for it.
	always @* begin
		ram_raddr = r_idx - `AACS_IDX_LIMIT_BASE;
		case (cmp_state_q)
			CMP_LOW: begin
				ram_raddr = {cmp_ch_q, 2'h0} - {2'h0, cmp_ch_q} + {2'h0, `AACS_LIM_LOW};
			end
			CMP_HIGH: begin
				ram_raddr = {cmp_ch_q, 2'h0} - {2'h0, cmp_ch_q} + {2'h0, `AACS_LIM_HIGH};
			end
			CMP_HYST: begin
				ram_raddr = {cmp_ch_q, 2'h0} - {2'h0, cmp_ch_q} + {2'h0, `AACS_LIM_HYST};
			end
			default: begin
				ram_raddr = r_idx - `AACS_IDX_LIMIT_BASE;
			end
		endcase
	end

	// A new event in the clearing cycle is applied after the clear, so it survives.
	always @* begin
		alert_d = alert_q;
		if (rd_alert || swrst) begin
			alert_d = 8'h00;
		end
		if (cmp_state_q == CMP_EVAL) begin
			if (over_high) begin
				alert_d[{cmp_ch_q, 1'b0}] = 1'b1;
			end else if (back_high) begin
				alert_d[{cmp_ch_q, 1'b0}] = 1'b0;
			end
			if (under_low) begin
				alert_d[{cmp_ch_q, 1'b1}] = 1'b1;
			end else if (back_low) begin
				alert_d[{cmp_ch_q, 1'b1}] = 1'b0;
			end
		end
	end

	// Bus write path.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awaddr_q     <= {`AACS_ADDR_W{1'b0}};
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AACS_RESP_OKAY;
			config_q     <= `AACS_CFG_RESET;
			chan_reg_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_ok ? `AACS_RESP_OKAY : `AACS_RESP_SLVERR;
				if (wr_cfg) begin
					config_q <= swrst ? `AACS_CFG_RESET : (wr_merged & `AACS_CFG_RW_MASK);
				end
				if (wr_chan && wstrb_q[0]) begin
					chan_reg_q <= wdata_q[3:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Bus read path; limit words take one extra cycle through the memory.
	always @(posedge aclk) begin
		if (!aresetn) begin
			ar_q         <= 1'b0;
			araddr_q     <= {`AACS_ADDR_W{1'b0}};
			rd_mem_q     <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `AACS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				ar_q     <= 1'b1;
				araddr_q <= s_axi_araddr;
			end
			rd_mem_q <= 1'b0;
			if (rd_mem_q) begin
				ar_q         <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `AACS_RESP_OKAY;
				s_axi_rdata  <= {20'h00000, ram_rdata};
			end else if (rd_go) begin
				if (r_ok && r_is_lim) begin
					rd_mem_q <= 1'b1;
				end else begin
					ar_q         <= 1'b0;
					s_axi_rvalid <= 1'b1;
					s_axi_rresp  <= r_ok ? `AACS_RESP_OKAY : `AACS_RESP_SLVERR;
					s_axi_rdata  <= 32'h0000_0000;
					if (r_ok) begin
						case (r_idx)
							`AACS_IDX_RESULT: begin
								s_axi_rdata <= {17'h00000, res_chan_q, any_alert, res_data_q};
							end
							`AACS_IDX_CHANNEL: begin
								s_axi_rdata <= {28'h0000000, chan_reg_q};
							end
							`AACS_IDX_CONFIG: begin
								s_axi_rdata <= {16'h0000, config_q};
							end
							default: begin
								s_axi_rdata <= {24'h000000, alert_q};
							end
						endcase
					end
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Cycle timer and its hold after a limit write.
	always @(posedge aclk) begin
		if (!aresetn) begin
			tmr_q        <= {`AACS_TMR_W{1'b0}};
			hold_edges_q <= 2'h0;
			scl_prev_q   <= 1'b1;
		end else begin
			scl_prev_q <= scl_sync;
			if (wr_lim && auto_mode) begin
				hold_edges_q <= 2'h2;
			end else if (hold_edges_q != 2'h0 && scl_edge) begin
				hold_edges_q <= hold_edges_q - 2'h1;
			end
			if (!auto_mode || wr_chan || wr_cfg) begin
				tmr_q <= {`AACS_TMR_W{1'b0}};
			end else if (hold_edges_q == 2'h0) begin
				tmr_q <= tmr_fire ? {`AACS_TMR_W{1'b0}} : tmr_q + 1'b1;
			end
		end
	end

	// Conversion launch and channel sequencing.
	always @(posedge aclk) begin
		if (!aresetn) begin
			conv_start_o  <= 1'b0;
			conv_chan_o   <= 2'h0;
			conv_q        <= 1'b0;
			cur_ch_q      <= 2'h0;
			active_mask_q <= 4'h0;
			chan_pend_q   <= 1'b0;
			stopped_q     <= 1'b0;
			res_chan_q    <= 2'h0;
			res_data_q    <= 12'h000;
		end else begin
			conv_start_o <= 1'b0;
			if (bus_stop_i && cmd_mode) begin
				stopped_q <= 1'b1;
			end else if (ext_conv_req_i || auto_mode) begin
				stopped_q <= 1'b0;
			end
			if (wr_chan || swrst) begin
				chan_pend_q <= 1'b1;
			end
			// Requests while converting or powered down are dropped, not queued.
			if (conv_req && !conv_q && config_q[`AACS_CFG_PD_UP]) begin
				conv_start_o <= 1'b1;
				conv_chan_o  <= cur_ch_q;
				conv_q       <= 1'b1;
			end
			if (conv_done_i && conv_q) begin
				conv_q     <= 1'b0;
				res_chan_q <= conv_chan_o;
				res_data_q <= conv_data_i;
				if (chan_pend_q && !(wr_chan || swrst)) begin
					active_mask_q <= chan_reg_q;
					cur_ch_q      <= lowest(chan_reg_q);
					chan_pend_q   <= 1'b0;
				end else begin
					cur_ch_q <= next_ch(active_mask_q, conv_chan_o);
				end
			end
		end
	end

	// Limit comparison after each conversion.
	always @(posedge aclk) begin
		if (!aresetn) begin
			cmp_state_q <= CMP_IDLE;
			cmp_ch_q    <= 2'h0;
			cmp_data_q  <= 12'h000;
			cmp_low_q   <= 12'h000;
			cmp_high_q  <= 12'h000;
			alert_q     <= 8'h00;
		end else begin
			alert_q <= alert_d;
			case (cmp_state_q)
				CMP_IDLE: begin
					if (conv_done_i && conv_q) begin
						cmp_ch_q    <= conv_chan_o;
						cmp_data_q  <= conv_data_i;
						cmp_state_q <= CMP_LOW;
					end
				end
				CMP_LOW: begin
					cmp_state_q <= CMP_HIGH;
				end
				CMP_HIGH: begin
					cmp_low_q   <= ram_rdata;
					cmp_state_q <= CMP_HYST;
				end
				CMP_HYST: begin
					cmp_high_q  <= ram_rdata;
					cmp_state_q <= CMP_EVAL;
				end
				CMP_EVAL: begin
					cmp_state_q <= CMP_IDLE;
				end
				default: begin
					cmp_state_q <= CMP_IDLE;
				end
			endcase
		end
	end

	// Shared pin: open drain only ever pulls low, so wired-low alerts can share a line.
	always @(posedge aclk) begin
		if (!aresetn) begin
			shared_status_pin_o  <= 1'b0;
			shared_status_pin_oe <= 1'b0;
		end else begin
			shared_status_pin_o <= config_q[`AACS_CFG_POL] ~^
				(config_q[`AACS_CFG_BUSY] ? conv_q : any_alert);
			shared_status_pin_oe <= config_q[`AACS_CFG_ALERT_EN] &&
				(config_q[`AACS_CFG_DRIVE] || !(config_q[`AACS_CFG_POL] ~^
				(config_q[`AACS_CFG_BUSY] ? conv_q : any_alert)));
		end
	end

endmodule // aacs_sequencer

`default_nettype wire

// ===== rtl/aacs_sync.v
`timescale 1ns/10ps
`default_nettype none

module aacs_sync (
	// Clock and reset
	input  wire aclk,
	input  wire aresetn,
	// Asynchronous input and its synchronised copy
	input  wire async_i,
	output reg  sync_o
);

	reg meta_q;

	// The serial clock idles high; resetting to that level avoids a false edge after reset.
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b1;
			sync_o <= 1'b1;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule // aacs_sync

`default_nettype wire

// ===== sim/aacs_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "aacs_map.vh"

module aacs_checker #(
	parameter integer BASE_CYCLES = 10
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	// Conversion and pin
	input wire logic        conv_start_o,
	input wire logic [1:0]  conv_chan_o,
	input wire logic        shared_status_pin_o,
	input wire logic        shared_status_pin_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// The design applies a configuration write a cycle or two after the handshake,
	// so checks that lean on this shadow wait until it has been quiet a while.
	logic [15:0] cfg_q;
	logic [3:0]  quiet_q;
	wire         cfg_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == {2'h0, `AACS_IDX_CONFIG, 2'h0};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= `AACS_CFG_RESET;
			quiet_q <= 4'hF;
		end else if (cfg_wr) begin
			cfg_q <= s_axi_wdata[9] ? `AACS_CFG_RESET : s_axi_wdata[15:0] & `AACS_CFG_RW_MASK;
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hF) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end

	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	chk_wr_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after handshake");
	chk_wr_err: assert property (s_wr_take ##0 (s_axi_awaddr[7:6] != 2'h0)
		|-> ##2 (s_axi_bvalid && s_axi_bresp == `AACS_RESP_SLVERR))
		else $error("unmapped write not refused");
	chk_rd_answer: assert property (s_rd_take |=> !s_axi_arready ##[1:6] s_axi_rvalid)
		else $error("read answer late or second read accepted");
	chk_rd_err: assert property (s_rd_take ##0 (s_axi_araddr[7:6] != 2'h0)
		|-> ##[1:5] (s_axi_rvalid && s_axi_rresp == `AACS_RESP_SLVERR && s_axi_rdata == 32'h0))
		else $error("unmapped read not refused");
	chk_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_start_pulse: assert property (conv_start_o |=> !conv_start_o)
		else $error("conversion start longer than one cycle");
	chk_chan_hold: assert property (!conv_start_o |-> $stable(conv_chan_o))
		else $error("channel changed without a start");
	chk_pin_off: assert property (quiet_q > 4'h4 && !cfg_q[4] |-> !shared_status_pin_oe)
		else $error("pin driven while its function is off");
	chk_busy_level: assert property (conv_start_o && quiet_q > 4'h4 && cfg_q[15]
		&& cfg_q[5:4] == 2'b11 |-> ##[1:2] (shared_status_pin_oe
		&& shared_status_pin_o == cfg_q[3]))
		else $error("busy level wrong during conversion");
	chk_open_drain: assert property (quiet_q > 4'h4 && !cfg_q[15] && shared_status_pin_oe
		|-> !shared_status_pin_o)
		else $error("open drain pin driven high");
endmodule // aacs_checker

bind aacs_sequencer aacs_checker #(.BASE_CYCLES(BASE_CYCLES)) u_chk (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.conv_start_o, .conv_chan_o, .shared_status_pin_o, .shared_status_pin_oe
);

`default_nettype wire

// ===== sim/aacs_conv_model.sv
`timescale 1ns/10ps
`default_nettype none

module aacs_conv_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Request from the sequencer; speed and channel values from the test
	input  wire logic        start,
	input  wire logic [1:0]  chan,
	input  wire logic        slow,
	input  wire logic [47:0] vals,
	// Result back
	output var  logic        done,
	output var  logic [11:0] data
);
	int         cnt_q;
	logic [1:0] ch_q;

	// Outside the done cycle the data lines toggle, so a late sample never passes.
	always @(posedge aclk) begin
		done <= 1'b0;
		if (!aresetn) begin
			cnt_q <= 0;
			data <= 12'h000;
		end else if (start) begin
			cnt_q <= slow ? 7 : 2;
			ch_q <= chan;
			data <= ~data;
		end else if (cnt_q == 1) begin
			cnt_q <= 0;
			done <= 1'b1;
			data <= vals[int'(ch_q) * 12 +: 12];
		end else begin
			if (cnt_q > 1)
				cnt_q <= cnt_q - 1;
			data <= ~data;
		end
	end
endmodule // aacs_conv_model

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "aacs_map.vh"

module testbench;
	localparam int         BC = 10;
	localparam logic [7:0] A_RES = {2'h0, `AACS_IDX_RESULT, 2'h0};
	localparam logic [7:0] A_CH = {2'h0, `AACS_IDX_CHANNEL, 2'h0};
	localparam logic [7:0] A_CFG = {2'h0, `AACS_IDX_CONFIG, 2'h0};
	localparam logic [7:0] A_AL = {2'h0, `AACS_IDX_ALERT, 2'h0};
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, scl_pin_i, bus_stop_i, ext_conv_req_i, conv_start_o;
	logic        conv_done_i, analog_on_o, ref_on_o, shared_status_pin_o, shared_status_pin_oe;
	logic        slow;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, conv_chan_o, c1, c2, lresp;
	logic [11:0] conv_data_i;
	logic [47:0] vals;
	int          errors, n_checks, k, g;

	aacs_sequencer #(.BASE_CYCLES(BC)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_pin_i, .bus_stop_i, .ext_conv_req_i,
		.conv_start_o, .conv_chan_o, .conv_done_i, .conv_data_i, .analog_on_o, .ref_on_o,
		.shared_status_pin_o, .shared_status_pin_oe);
	aacs_conv_model u_core (.aclk, .aresetn, .start(conv_start_o), .chan(conv_chan_o), .slow,
		.vals, .done(conv_done_i), .data(conv_data_i));

	function automatic logic [7:0] lim(input int n, input int j);
		return 8'(4 * (int'(`AACS_IDX_LIMIT_BASE) + 3 * n + j));
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		lresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		lresp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
		n_checks++;
		if (v !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic cnt(input int n, output int s);
		s = 0;
		repeat (n) begin
			@(posedge aclk);
			if (conv_start_o) s++;
		end
	endtask
	// Measures start to start; the first edge skips a start still showing on entry.
	task automatic gap(output int n, output logic [1:0] ch);
		do @(posedge aclk); while (conv_start_o !== 1'b1);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (conv_start_o !== 1'b1);
		ch = conv_chan_o;
	endtask
	task automatic req();
		@(posedge aclk) ext_conv_req_i <= 1'b1;
		@(posedge aclk) ext_conv_req_i <= 1'b0;
		repeat (20) @(posedge aclk);
	endtask
	task automatic tdone(input string n);
		$display("test %s finished", n);
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial begin
		#5_000_000;
		errors++;
		$display("[ERR] watchdog expired");
		results();
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{bus_stop_i, ext_conv_req_i, slow, aresetn} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		scl_pin_i = 1'b1;
		vals = 48'h400400400400;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_CFG, d); chk("config", 32'h00C3, d);
		rd(lim(0, 1), d); chk("high limit", 32'hFFF, d);
		tdone("reset");
		wr(A_CH, 32'hA);
		for (int c = 0; c < 4; c++) begin
			slow <= c[0];
			wr(A_CFG, 32'h813B | (c << 6));
			gap(g, c1);
			gap(g, c1);
			chk("interval", BC << c, g);
			do @(posedge aclk); while (conv_start_o !== 1'b1);
			c2 = conv_chan_o;
			chk("sequence", 2'h2, c1 ^ c2);
		end
		gap(g, c1);
		repeat (40) @(posedge aclk);
		wr(A_CH, 32'hA); cnt(70, k); chk("restart", 0, k);
		wr(A_CFG, 32'h813B); wr(A_CH, 0);
		gap(g, c1); gap(g, c1); chk("zero mask", 0, c1);
		wr(lim(0, 0), 0); cnt(40, k); chk("stall", 0, k);
		fork
			repeat (2) #400 scl_pin_i <= ~scl_pin_i;
			cnt(40, k);
		join
		chk("resume", 1, k >= 3);
		@(posedge aclk) bus_stop_i <= 1'b1;
		@(posedge aclk) bus_stop_i <= 1'b0;
		cnt(40, k); chk("stop", 1, k >= 3);
		tdone("autocycle");
		wr(A_CFG, 32'h0003);
		wr(lim(1, 0), 32'h100); wr(lim(1, 1), 32'h800); wr(lim(1, 2), 32'h050);
		wr(A_CH, 32'h2);
		vals[23:12] <= 12'h900;
		wr(A_CFG, 32'h0113); repeat (40) @(posedge aclk);
		chk("pin", 2'b10, {shared_status_pin_oe, shared_status_pin_o});
		rd(A_RES, d); chk("result", 32'h3900, d);
		vals[23:12] <= 12'h7A0;
		repeat (40) @(posedge aclk);
		chk("pin hyst", 1'b0, shared_status_pin_oe);
		rd(A_RES, d); chk("result hyst", 32'h27A0, d);
		vals[23:12] <= 12'h900;
		repeat (40) @(posedge aclk);
		wr(A_CFG, 32'h0013); repeat (20) @(posedge aclk);
		rd(A_AL, d); chk("alert high", 32'h4, d);
		rd(A_AL, d); chk("alert clear", 32'h0, d);
		chk("pin clear", 1'b0, shared_status_pin_oe);
		vals[23:12] <= 12'h050;
		for (int i = 0; i < 2; i++) begin
			wr(A_CFG, i ? 32'h0513 : 32'h0013); req();
			rd(A_AL, d); chk("alert low", 32'h8, d);
		end
		req(); chk("pin low", 1'b1, shared_status_pin_oe);
		wr(A_CFG, 32'h0200); rd(A_AL, d); chk("soft reset", 0, d);
		rd(A_CFG, d); chk("soft reset config", 32'h00C3, d);
		tdone("alert");
		wr(A_CFG, 32'h0403); @(posedge aclk) bus_stop_i <= 1'b1;
		@(posedge aclk) bus_stop_i <= 1'b0;
		@(posedge aclk) chk("stop sleep", 1'b0, analog_on_o);
		req(); chk("stop wake", 1'b1, analog_on_o);
		wr(A_CFG, 32'h0000); chk("down", 2'b00, {analog_on_o, ref_on_o});
		rd(A_RES, d); chk("read in down", 12'h050, d[11:0]);
		wr(A_CFG, 32'h0002); chk("bias", 2'b10, {analog_on_o, ref_on_o});
		// No conversion follows, which leaves the reference its settling time.
		wr(A_CFG, 32'h0003); chk("reference", 2'b11, {analog_on_o, ref_on_o});
		rd(8'h40, d); chk("bad read", 32'h0, d);
		chk("bad read resp", {30'h0, `AACS_RESP_SLVERR}, {30'h0, lresp});
		wr(8'h44, 32'h1); chk("bad write", `AACS_RESP_SLVERR, lresp);
		tdone("power and bus");
		results();
	end
endmodule // testbench

`default_nettype wire
